// >>> rtl/shs_homing_seq.sv
// Homing sequencer top: APB registers, reference movement and dimension setting
//
// Overview of operation
// - Homing establishes absolute motor position reference
// - Reference movement or dimension setting offered
// - Completed movement point becomes zero point
// - Configurable offset shifts the zero point
// - Zero valid only after full movement, dimension setting or valid absolute encoder at reset
// - Mode change refused while movement busy
// - Dimension setting loads requested current position
// - Valid multiturn absolute encoder skips homing
// - Four movements: both end switches, home both
// - Movement finishes with or without index
// - Without index move configured distance past edge
// - With index move to next index pulse
// - Position readable; index pulse equals zero
// - Progress shown in axis and mode status
// - Home switch evaluated only during its search
// - Switch setting 0 none (home switch: NC), 1 NC, 2 NO
`timescale 1ns/10ps
`default_nettype none
`include "shs_regs.svh"
module shs_homing_seq
  import shs_pkg::*;
#(
  parameter int STEP_CYCLES = `SHS_STEP_CYCLES
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Switches and encoder
  input  wire logic        negative_end_switch,
  input  wire logic        positive_end_switch,
  input  wire logic        home_switch,
  input  wire logic        index_pulse,
  input  wire logic        encoder_abs_valid,
  // Motion output
  output logic             move_active,
  output logic             move_dir_pos,
  output logic             move_step
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  shs_sw_if      sw ();
  shs_method_t   method;
  shs_state_t    state_reg;
  logic [31:0]   axis_ctrl_reg;
  logic [3:0]    op_mode_reg;
  logic [7:0]    method_reg;
  logic [31:0]   offset_reg;
  logic [31:0]   distance_reg;
  logic [31:0]   dim_value_reg;
  logic [5:0]    swcfg_reg;
  logic [31:0]   position_reg;
  logic [31:0]   zero_reg;
  logic [31:0]   travel_reg;
  logic [15:0]   step_cnt_reg;
  logic          valid_reg;
  logic          done_reg;
  logic          aborted_reg;
  logic          error_reg;
  logic          refused_reg;
  logic          enc_seen_reg;
  logic          target_hit;
  logic          step_tick;
  logic          wr_en;
  logic          rd_en;
  logic          start_req;
  logic          abort_req;
  logic          busy;
  logic [31:0]   rd_mux;
  logic          rd_ok;
  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  shs_switch_eval u_eval (
    .pclk                         (pclk),
    .presetn                      (presetn),
    .negative_end_switch          (negative_end_switch),
    .positive_end_switch          (positive_end_switch),
    .home_switch                  (home_switch),
    .negative_end_switch_polarity (swcfg_reg[1:0]),
    .positive_end_switch_polarity (swcfg_reg[3:2]),
    .home_switch_polarity         (swcfg_reg[5:4]),
    .sw                           (sw)
  );
  shs_method_dec u_dec (
    .homing_method_code (method_reg),
    .method             (method)
  );
  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr_en     = psel & penable & pwrite;
  assign rd_en     = psel & penable & ~pwrite;
  assign busy      = (state_reg == SHS_SEARCH) | (state_reg == SHS_LEAVE) | (state_reg == SHS_INDEX);
  assign start_req = wr_en & (paddr == `SHS_OFF_AXIS_CTRL) & pwdata[`SHS_CTRL_START]
                     & pwdata[`SHS_CTRL_ENABLE] & (op_mode_reg == `SHS_MODE_HOMING);
  assign abort_req = wr_en & (paddr == `SHS_OFF_AXIS_CTRL) & pwdata[`SHS_CTRL_ABORT];
  assign sw.home_enable = (state_reg == SHS_SEARCH) & (method.target == SHS_TGT_HOME);
  always_comb begin
    case (method.target)
      SHS_TGT_NEG:  target_hit = sw.neg_active;
      SHS_TGT_POS:  target_hit = sw.pos_active;
      default:      target_hit = sw.home_active;
    endcase
  end
  always_comb begin
    rd_ok = 1'b1;
    case (paddr)
      `SHS_OFF_AXIS_CTRL:  rd_mux = axis_ctrl_reg;
      `SHS_OFF_MODE_CTRL:  rd_mux = {28'h0000000, op_mode_reg};
      `SHS_OFF_METHOD:     rd_mux = {24'h000000, method_reg};
      `SHS_OFF_OFFSET:     rd_mux = offset_reg;
      `SHS_OFF_DISTANCE:   rd_mux = distance_reg;
      `SHS_OFF_DIM_VALUE:  rd_mux = dim_value_reg;
      `SHS_OFF_SWITCH_CFG: rd_mux = {26'h0000000, swcfg_reg};
      `SHS_OFF_AXIS_STAT:  rd_mux = {26'h0000000, refused_reg, error_reg, aborted_reg, done_reg, busy, valid_reg};
      `SHS_OFF_MODE_STAT:  rd_mux = {25'h0000000, state_reg, op_mode_reg};
      `SHS_OFF_POSITION:   rd_mux = position_reg;
      `SHS_OFF_ZERO_POINT: rd_mux = zero_reg;
      default: begin
        rd_mux = 32'h00000000;
        rd_ok  = 1'b0;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
      pslverr <= psel & ~penable & ~rd_ok;
    end
  end
  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_ctrl_reg <= 32'h00000000;
      op_mode_reg   <= 4'h0;
      method_reg    <= `SHS_METHOD_RST;
      offset_reg    <= 32'h00000000;
      distance_reg  <= 32'h00000000;
      dim_value_reg <= 32'h00000000;
      swcfg_reg     <= 6'(`SHS_SWCFG_RST);
    end else if (wr_en & pready) begin
      case (paddr)
        `SHS_OFF_AXIS_CTRL:  axis_ctrl_reg <= pwdata & 32'h00000001;
        `SHS_OFF_MODE_CTRL:  op_mode_reg   <= busy ? op_mode_reg : pwdata[3:0];
        `SHS_OFF_METHOD:     method_reg    <= busy ? method_reg : pwdata[7:0];
        `SHS_OFF_OFFSET:     offset_reg    <= pwdata;
        `SHS_OFF_DISTANCE:   distance_reg  <= pwdata;
        `SHS_OFF_DIM_VALUE:  dim_value_reg <= pwdata;
        `SHS_OFF_SWITCH_CFG: swcfg_reg     <= pwdata[5:0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Homing state machine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= SHS_IDLE;
      travel_reg <= 32'h00000000;
    end else begin
      case (state_reg)
        SHS_IDLE, SHS_DONE, SHS_FAIL: begin
          if (start_req & pready & ~method.set_dim)
            state_reg <= method.valid ? SHS_SEARCH : SHS_FAIL;
        end
        SHS_SEARCH: begin
          if (abort_req & pready)
            state_reg <= SHS_FAIL;
          else if (target_hit) begin
            state_reg  <= method.use_index ? SHS_INDEX : SHS_LEAVE;
            travel_reg <= 32'h00000000;
          end
        end
        SHS_LEAVE: begin
          if (abort_req & pready)
            state_reg <= SHS_FAIL;
          else if (travel_reg >= distance_reg)
            state_reg <= SHS_DONE;
          else if (step_tick)
            travel_reg <= travel_reg + 32'h00000001;
        end
        SHS_INDEX: begin
          if (abort_req & pready)
            state_reg <= SHS_FAIL;
          else if (index_pulse)
            state_reg <= SHS_DONE;
        end
        default: state_reg <= SHS_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Step generation
  // ----------------------------------------------------------------
  assign step_tick = (step_cnt_reg == 16'(STEP_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_reg <= 16'h0000;
      move_step    <= 1'b0;
      move_active  <= 1'b0;
      move_dir_pos <= 1'b0;
    end else begin
      step_cnt_reg <= (busy & ~step_tick) ? step_cnt_reg + 16'h0001 : 16'h0000;
      move_step    <= busy & step_tick;
      move_active  <= busy;
      move_dir_pos <= (state_reg == SHS_SEARCH) ? method.dir_pos : ~method.dir_pos;
    end
  end
  // ----------------------------------------------------------------
  // Position and zero point
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      position_reg <= 32'h00000000;
      zero_reg     <= 32'h00000000;
    end else if (start_req & pready & method.set_dim & ~busy) begin
      position_reg <= dim_value_reg;
      zero_reg     <= 32'h00000000;
    end else if (busy & ~(abort_req & pready) &
                 ((state_reg == SHS_INDEX) ? index_pulse : (state_reg == SHS_LEAVE) & (travel_reg >= distance_reg))) begin
      position_reg <= offset_reg;
      zero_reg     <= offset_reg;
    end else if (busy & step_tick) begin
      position_reg <= move_dir_pos ? position_reg + 32'h00000001 : position_reg - 32'h00000001;
    end
  end
  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_reg    <= 1'b0;
      enc_seen_reg <= 1'b0;
      done_reg     <= 1'b0;
      aborted_reg  <= 1'b0;
      error_reg    <= 1'b0;
      refused_reg  <= 1'b0;
    end else begin
      enc_seen_reg <= 1'b1;
      if (~enc_seen_reg)
        valid_reg <= encoder_abs_valid;
      else if (busy & abort_req & pready)
        valid_reg <= 1'b0;
      else if (busy & (state_reg != SHS_SEARCH) & ((state_reg == SHS_INDEX) ? index_pulse : travel_reg >= distance_reg))
        valid_reg <= 1'b1;
      else if (start_req & pready & method.set_dim & ~busy)
        valid_reg <= 1'b1;
      if (start_req & pready) begin
        done_reg    <= method.set_dim & ~busy;
        aborted_reg <= 1'b0;
        error_reg   <= ~method.valid & ~busy;
      end else if (busy & abort_req & pready)
        aborted_reg <= 1'b1;
      else if (busy & (state_reg != SHS_SEARCH) & ((state_reg == SHS_INDEX) ? index_pulse : travel_reg >= distance_reg))
        done_reg <= 1'b1;
      if (wr_en & pready & (paddr == `SHS_OFF_MODE_CTRL))
        refused_reg <= busy;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/shs_regs.svh
// Register offsets, field positions, reset values and timing counts of the homing sequencer
`ifndef SHS_REGS_SVH
`define SHS_REGS_SVH
`define SHS_OFF_AXIS_CTRL   12'h000
`define SHS_OFF_MODE_CTRL   12'h004
`define SHS_OFF_METHOD      12'h008
`define SHS_OFF_OFFSET      12'h00C
`define SHS_OFF_DISTANCE    12'h010
`define SHS_OFF_DIM_VALUE   12'h014
`define SHS_OFF_SWITCH_CFG  12'h018
`define SHS_OFF_AXIS_STAT   12'h01C
`define SHS_OFF_MODE_STAT   12'h020
`define SHS_OFF_POSITION    12'h024
`define SHS_OFF_ZERO_POINT  12'h028
`define SHS_CTRL_ENABLE     0
`define SHS_CTRL_START      1
`define SHS_CTRL_ABORT      2
`define SHS_STAT_VALID      0
`define SHS_STAT_BUSY       1
`define SHS_STAT_DONE       2
`define SHS_STAT_ABORTED    3
`define SHS_STAT_ERROR      4
`define SHS_STAT_REFUSED    5
`define SHS_MODE_HOMING     4'h6
`define SHS_METHOD_DIM      8'h23
`define SHS_METHOD_RST      8'h12
`define SHS_SWCFG_RST       32'h0000_0012
`define SHS_STEP_CYCLES     16
`endif

// >>> rtl/shs_pkg.sv
// Types shared by the homing sequencer modules
package shs_pkg;
  typedef enum logic [2:0] {
    SHS_IDLE,
    SHS_SEARCH,
    SHS_LEAVE,
    SHS_INDEX,
    SHS_DONE,
    SHS_FAIL
  } shs_state_t;
  typedef enum logic [1:0] {
    SHS_TGT_NEG,
    SHS_TGT_POS,
    SHS_TGT_HOME
  } shs_target_t;
  typedef struct packed {
    logic        valid;
    shs_target_t target;
    logic        dir_pos;
    logic        use_index;
    logic        set_dim;
  } shs_method_t;
endpackage

// >>> rtl/shs_sw_if.sv
// Interface carrying evaluated switch states to the sequencer
`timescale 1ns/10ps
`default_nettype none
interface shs_sw_if;
  logic neg_active;
  logic pos_active;
  logic home_active;
  logic home_enable;
  modport filt (input home_enable, output neg_active, output pos_active, output home_active);
  modport seq  (output home_enable, input neg_active, input pos_active, input home_active);
endinterface
`default_nettype wire

// >>> rtl/shs_switch_eval.sv
// Switch evaluation per polarity setting
`timescale 1ns/10ps
`default_nettype none
module shs_switch_eval
  import shs_pkg::*;
(
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Raw switch inputs
  input  wire logic  negative_end_switch,
  input  wire logic  positive_end_switch,
  input  wire logic  home_switch,
  // Polarity settings
  input  wire logic [1:0] negative_end_switch_polarity,
  input  wire logic [1:0] positive_end_switch_polarity,
  input  wire logic [1:0] home_switch_polarity,
  // Evaluated states
  shs_sw_if.filt     sw
);
  function automatic logic eval_sw(input logic raw, input logic [1:0] pol);
    case (pol)
      2'h1: eval_sw = ~raw;
      2'h2: eval_sw = raw;
      default: eval_sw = 1'b0;
    endcase
  endfunction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw.neg_active  <= 1'b0;
      sw.pos_active  <= 1'b0;
      sw.home_active <= 1'b0;
    end else begin
      sw.neg_active  <= eval_sw(negative_end_switch, negative_end_switch_polarity);
      sw.pos_active  <= eval_sw(positive_end_switch, positive_end_switch_polarity);
      sw.home_active <= sw.home_enable &
                        eval_sw(home_switch, (home_switch_polarity == 2'h0) ? 2'h1 : home_switch_polarity);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/shs_method_dec.sv
// Decoder of the homing method code
`timescale 1ns/10ps
`default_nettype none
module shs_method_dec
  import shs_pkg::*;
(
  // Method code in
  input  wire logic [7:0] homing_method_code,
  // Decoded method out
  output var  shs_method_t method
);
  always_comb begin
    method = '{valid: 1'b1, target: SHS_TGT_NEG, dir_pos: 1'b0, use_index: 1'b0, set_dim: 1'b0};
    case (homing_method_code)
      8'h01: method.use_index = 1'b1;
      8'h02: begin
        method.target = SHS_TGT_POS;
        method.dir_pos = 1'b1;
        method.use_index = 1'b1;
      end
      8'h08, 8'h09, 8'h0A: begin
        method.target = SHS_TGT_HOME;
        method.dir_pos = 1'b1;
        method.use_index = 1'b1;
      end
      8'h0B, 8'h0C, 8'h0D, 8'h0E: begin
        method.target = SHS_TGT_HOME;
        method.use_index = 1'b1;
      end
      8'h11: ;
      8'h12: begin
        method.target = SHS_TGT_POS;
        method.dir_pos = 1'b1;
      end
      8'h17, 8'h18, 8'h19, 8'h1A: begin
        method.target = SHS_TGT_HOME;
        method.dir_pos = 1'b1;
      end
      8'h1B, 8'h1C, 8'h1D, 8'h1E: method.target = SHS_TGT_HOME;
      `SHS_METHOD_DIM: method.set_dim = 1'b1;
      default: method.valid = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// >>> verification/shs_homing_seq_checker.sv
// Port assertions of the homing sequencer
`timescale 1ns/10ps
`default_nettype none
module shs_homing_seq_checker #(
  parameter int STEP_CYCLES = 16
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Motion
  input  wire logic        move_active,
  input  wire logic        move_step
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Cycles since the last step
  // ----------------------------------------
  logic [7:0] gap_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_reg <= 8'hFF;
    else if (!move_active) gap_reg <= 8'hFF;
    else if (move_step) gap_reg <= 8'h01;
    else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
  end
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; psel && penable && pready; endsequence
  sequence s_rd; s_acc ##0 !pwrite; endsequence
  sequence s_abort; s_acc ##0 (pwrite && paddr == 12'h000 && pwdata[2] && move_active); endsequence
  property p_rdy_next; s_setup |=> pready; endproperty
  property p_rdy_pulse; pready |=> !pready; endproperty
  property p_rdy_cause; pready |-> psel && penable && $past(psel && !penable); endproperty
  property p_err_unmap; s_rd ##0 (paddr > 12'h028) |-> pslverr && prdata == 32'h0; endproperty
  property p_err_map; s_acc ##0 (pwrite || (paddr <= 12'h028 && paddr[1:0] == 2'h0)) |-> !pslverr; endproperty
  property p_step_act; move_step |-> move_active; endproperty
  property p_step_gap; move_step |-> int'(gap_reg) >= STEP_CYCLES; endproperty
  property p_abort; s_abort |-> ##[1:3] !move_active; endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("no ready after setup");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready without access");
  a_err_unmap: assert property (p_err_unmap) else $error("unmapped read not flagged");
  a_err_map: assert property (p_err_map) else $error("error on valid access");
  a_step_act: assert property (p_step_act) else $error("step while idle");
  a_step_gap: assert property (p_step_gap) else $error("steps too close");
  a_abort: assert property (p_abort) else $error("abort did not stop");
endmodule
`default_nettype wire

// >>> verification/shs_fb_master.sv
// Fieldbus master model driving the APB register port
`timescale 1ns/10ps
`default_nettype none
module shs_fb_master (
  // Clock
  input  wire logic        pclk,
  // APB master
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic        pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer, held until ready; released lines are scrambled
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
endmodule
`default_nettype wire

// >>> verification/servo_homing_sequencer_tb_top.sv
// Testbench top of the homing sequencer
`timescale 1ns/10ps
`default_nettype none
module servo_homing_sequencer_tb_top;
  typedef struct packed { logic [31:0] mask; logic [31:0] val; logic err; } shs_exp_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        neg_sw = 1'b0;
  logic        pos_sw = 1'b0;
  logic        home_sw = 1'b0;
  logic        idx = 1'b0;
  logic        absv = 1'b0;
  wire logic   psel, penable, pwrite, pready, pslverr, move_active, move_dir_pos, move_step;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  shs_exp_t    exp_q[$];
  shs_exp_t    mon_e;
  logic [31:0] off;
  logic [7:0]  codes [4] = '{8'h11, 8'h12, 8'h0A, 8'h0E};
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #10 pclk = ~pclk;
  shs_fb_master u_fb (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
                      .paddr(paddr), .pwdata(pwdata), .pready(pready));
  shs_homing_seq #(.STEP_CYCLES(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .negative_end_switch(neg_sw), .positive_end_switch(pos_sw),
    .home_switch(home_sw), .index_pulse(idx), .encoder_abs_valid(absv), .move_active(move_active),
    .move_dir_pos(move_dir_pos), .move_step(move_step));
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      end_sim();
    end
  end
  // Read results compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) check(prdata, 32'hDEAD_BEEF);
      else begin
        mon_e = exp_q.pop_front();
        check(prdata & mon_e.mask, mon_e.val);
        check({31'h0, pslverr}, {31'h0, mon_e.err});
      end
    end
  end
  // ----------------------------------------
  // Bus helpers
  // ----------------------------------------
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v, input logic e = 1'b0);
    exp_q.push_back('{m, v, e});
    u_fb.rd(a);
  endtask
  task automatic start(input logic [7:0] code);
    u_fb.wr(12'h004, 32'h6);
    u_fb.wr(12'h008, {24'h0, code});
    u_fb.wr(12'h000, 32'h3);
  endtask
  task automatic run_out;
    for (int k = 0; k < 300 && move_active !== 1'b0; k++) begin
      @(posedge pclk);
      idx <= (k % 8 == 7);
    end
    idx <= 1'b0;
    check({31'h0, move_active}, 32'h0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(66677));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h01C, 32'h1, 32'h0);
    rd(12'h008, 32'hFF, 32'h12);
    rd(12'h018, 32'h3F, 32'h12);
    rd(12'h100, 32'hFFFF_FFFF, 32'h0, 1'b1);
    $display("test reset done");
    off = $urandom;
    u_fb.wr(12'h014, off);
    start(8'h23);
    rd(12'h024, 32'hFFFF_FFFF, off);
    rd(12'h01C, 32'h5, 32'h5);
    $display("test dimension done");
    u_fb.wr(12'h018, 32'h2A);
    u_fb.wr(12'h010, 32'h3);
    for (int i = 0; i < 4; i++) begin
      off = $urandom;
      u_fb.wr(12'h00C, off);
      start(codes[i]);
      repeat (4) @(posedge pclk);
      check({31'h0, move_dir_pos}, {31'h0, (i == 1 || i == 2)});
      u_fb.wr(12'h004, 32'h1);
      rd(12'h01C, 32'h22, 32'h22);
      rd(12'h020, 32'hF, 32'h6);
      case (i)
        0: neg_sw <= 1'b1;
        1: pos_sw <= 1'b1;
        default: home_sw <= 1'b1;
      endcase
      run_out();
      rd(12'h024, 32'hFFFF_FFFF, off);
      rd(12'h028, 32'hFFFF_FFFF, off);
      rd(12'h01C, 32'h5, 32'h5);
      {neg_sw, pos_sw, home_sw} <= 3'h0;
      $display("test movement %0d done", i);
    end
    u_fb.wr(12'h018, 32'h22);
    start(8'h11);
    repeat (4) @(posedge pclk);
    u_fb.wr(12'h000, 32'h5);
    run_out();
    rd(12'h01C, 32'h9, 32'h8);
    $display("test abort done");
    start(8'h05);
    rd(12'h01C, 32'h10, 32'h10);
    $display("test bad code done");
    absv <= 1'b1;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h01C, 32'h1, 32'h1);
    $display("test absolute encoder done");
    repeat (3) @(posedge pclk);
    end_sim();
  end
endmodule
bind shs_homing_seq shs_homing_seq_checker #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .move_active(move_active), .move_step(move_step));
`default_nettype wire
